//--- logic/eep_slave.sv
// Two-wire bus slave front end of a 512 x 8 serial EEPROM.
`timescale 1ns/100ps
module eep_slave
#(
  parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES,
  parameter logic [3:0] DEV_SEL = 4'h5 // Arbitrary device select code.
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic WP,
  output logic BUSY,
  output logic ADDRESSED
);

  // ---------------------------------------------------------------
  // Line synchronisation and condition detection
  // ---------------------------------------------------------------
  logic [2:0] line_f;
  logic scl_f;
  logic sda_f;
  logic scl_q_reg;
  logic sda_q_reg;

  eep_line_filter u_filter
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .line_in({WP, SDA_IN, SCL}),
    .line_out(line_f)
  );

  assign scl_f = line_f[0];
  assign sda_f = line_f[1];

  // Previous filtered levels for edge finding.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end
    else
    begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  // Clock edges and line conditions seen on the filtered lines.
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = scl_f & ~scl_q_reg;
  assign scl_fall = ~scl_f & scl_q_reg;
  assign start_cond = scl_f & scl_q_reg & sda_q_reg & ~sda_f; // R9
  assign stop_cond = scl_f & scl_q_reg & ~sda_q_reg & sda_f; // R10

  // ---------------------------------------------------------------
  // Sequencer storage
  // ---------------------------------------------------------------
  eep_pkg::eep_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic sda_oe_reg;
  logic rack_reg;
  logic [eep_pkg::ADDR_W-1:0] addr_reg;
  logic [7:0] mem [eep_pkg::MEM_BYTES];
  logic [7:0] pbuf [eep_pkg::PAGE_BYTES];
  logic [eep_pkg::PAGE_BYTES-1:0] pmask_reg;
  logic [eep_pkg::PAGE_W-1:0] page_reg;
  logic busy_reg;
  logic [eep_pkg::PROG_CNT_W-1:0] prog_cnt_reg;

  // ---------------------------------------------------------------
  // Decoding of bytes and events
  // ---------------------------------------------------------------
  logic [7:0] rx_byte;
  logic byte_done;
  logic cmd_match;
  logic cmd_read;
  logic [7:0] rd_byte;
  logic [eep_pkg::OFFS_W-1:0] offs;
  logic wdata_store;
  logic prog_start;
  logic prog_done;
  logic [eep_pkg::PROG_CNT_W-1:0] prog_load;
  logic mask_clear;

  // Byte completes at the falling edge that follows the eighth rising edge.
  assign rx_byte = rx_reg;
  assign byte_done = scl_fall && (bit_cnt_reg == eep_pkg::BITS_PER_BYTE); // R15
  // Busy blocks the command acknowledge so the master can poll.
  assign cmd_match = (rx_byte[eep_pkg::CMD_SEL_HI:eep_pkg::CMD_SEL_LO] == DEV_SEL)
                     && !busy_reg; // R24 R6
  assign cmd_read = rx_byte[eep_pkg::CMD_DIR_BIT]; // R17
  assign rd_byte = mem[addr_reg];
  assign offs = addr_reg[eep_pkg::OFFS_W-1:0];
  assign wdata_store = byte_done && (state_reg == eep_pkg::ST_WDATA);
  // A stop closing a write programs unless protected; a refused stop drops the entries.
  assign prog_start = stop_cond && (|pmask_reg) && !line_f[2] && !busy_reg; // R11 R3
  assign mask_clear = prog_done || (stop_cond && !busy_reg && !prog_start) // R3 R11
                      || (byte_done && (state_reg == eep_pkg::ST_CMD) && cmd_match && !cmd_read);
  assign prog_done = busy_reg && (prog_cnt_reg == '0); // R8
  assign prog_load = eep_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

  // ---------------------------------------------------------------
  // Slave sequencer
  // ---------------------------------------------------------------
  // Bits are taken on rising edges and the pin moves only on falling edges.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= eep_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      rack_reg <= 1'b0;
      addr_reg <= '0;
    end
    else if (start_cond)
    begin
      state_reg <= eep_pkg::ST_CMD; // R16
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_reg <= eep_pkg::ST_IDLE; // R10 R8
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        eep_pkg::ST_IDLE:
        begin
          sda_oe_reg <= 1'b0;
        end
        eep_pkg::ST_CMD, eep_pkg::ST_ADDR, eep_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            rx_reg <= {rx_reg[6:0], sda_f}; // R1 R15
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == eep_pkg::ST_CMD)
            begin
              if (cmd_match)
              begin
                state_reg <= eep_pkg::ST_CMD_ACK;
                sda_oe_reg <= 1'b1; // R13 R12
                if (!cmd_read)
                begin
                  addr_reg[eep_pkg::ADDR_W-1] <= rx_byte[eep_pkg::CMD_UPPER_ADDR_BIT]; // R18
                end
              end
              else
              begin
                state_reg <= eep_pkg::ST_IDLE; // R6
              end
            end
            else if (state_reg == eep_pkg::ST_ADDR)
            begin
              addr_reg[7:0] <= rx_byte; // R19
              state_reg <= eep_pkg::ST_ADDR_ACK;
              sda_oe_reg <= 1'b1; // R13
            end
            else
            begin
              state_reg <= eep_pkg::ST_WDATA_ACK;
              sda_oe_reg <= 1'b1; // R13
            end
          end
        end
        eep_pkg::ST_CMD_ACK:
        begin
          if (scl_fall)
          begin
            if (cmd_read)
            begin
              // First data bit goes out on the fall that ends the acknowledge.
              state_reg <= eep_pkg::ST_RDATA; // R20
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7]; // R2 R14
            end
            else
            begin
              state_reg <= eep_pkg::ST_ADDR;
              sda_oe_reg <= 1'b0; // R12
            end
          end
        end
        eep_pkg::ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            state_reg <= eep_pkg::ST_WDATA;
            sda_oe_reg <= 1'b0;
          end
        end
        eep_pkg::ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            state_reg <= eep_pkg::ST_WDATA;
            sda_oe_reg <= 1'b0;
            addr_reg[eep_pkg::OFFS_W-1:0] <= offs + 4'h1; // R22 R23
          end
        end
        eep_pkg::ST_RDATA:
        begin
          if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            // Release for the master's acknowledge and advance past the byte.
            state_reg <= eep_pkg::ST_RACK;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0; // R12
            addr_reg <= addr_reg + 9'h001; // R22
          end
          else if (scl_fall)
          begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= ~tx_reg[6]; // R1 R2 R14
          end
        end
        eep_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            rack_reg <= ~sda_f;
          end
          else if (scl_fall)
          begin
            if (rack_reg)
            begin
              state_reg <= eep_pkg::ST_RDATA; // R20
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
            end
            else
            begin
              state_reg <= eep_pkg::ST_IDLE; // R21
              sda_oe_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------
  // Entry mask clears when a write command is taken, after programming, and at a stop that does not start programming while idle.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pmask_reg <= '0;
      page_reg <= '0;
    end
    else if (mask_clear)
    begin
      pmask_reg <= '0;
    end
    else if (wdata_store)
    begin
      pmask_reg[offs] <= 1'b1; // R4
      page_reg <= addr_reg[eep_pkg::ADDR_W-1:eep_pkg::OFFS_W]; // R23
    end
  end

  genvar p;
  generate
    for (p = 0; p < eep_pkg::PAGE_BYTES; p++)
    begin : g_pbuf
      // Each entry takes the byte received at its in-page offset.
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          pbuf[p] <= eep_pkg::ERASED_BYTE;
        end
        else if (wdata_store && (offs == eep_pkg::OFFS_W'(p)))
        begin
          pbuf[p] <= rx_byte;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Programming timer
  // ---------------------------------------------------------------
  // Counts the erase/write time; the array is updated as it expires.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end
    else if (prog_start)
    begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= prog_load; // R25
    end
    else if (prog_done)
    begin
      busy_reg <= 1'b0; // R8
    end
    else if (busy_reg)
    begin
      prog_cnt_reg <= prog_cnt_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Memory array
  // ---------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < eep_pkg::MEM_BYTES; m++)
    begin : g_mem
      localparam logic [eep_pkg::ADDR_W-1:0] MADDR = eep_pkg::ADDR_W'(m);
      logic hit;
      assign hit = prog_done && (MADDR[eep_pkg::ADDR_W-1:eep_pkg::OFFS_W] == page_reg)
                   && pmask_reg[MADDR[eep_pkg::OFFS_W-1:0]];

      // Only addressed bytes of the one page are rewritten together.
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          mem[m] <= eep_pkg::ERASED_BYTE;
        end
        else if (hit)
        begin
          mem[m] <= pbuf[MADDR[eep_pkg::OFFS_W-1:0]]; // R4
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The pin value is always low; only the enable moves.
  assign SDA_OUT = 1'b0; // R2
  assign SDA_OE = sda_oe_reg;
  assign BUSY = busy_reg;
  assign ADDRESSED = (state_reg != eep_pkg::ST_IDLE) && (state_reg != eep_pkg::ST_CMD);

endmodule : eep_slave

//--- logic/eep_pkg.sv
// Shared constants for the two-wire serial EEPROM slave front end.
//
// How it works
// R1 - Incoming bits are taken on clock rise; outgoing bits change after clock fall.
// R2 - The data pin is only pulled low or released, never driven high.
// R3 - Write-protect high refuses all programming; low allows normal reads and writes.
// R4 - Storage is 512 bytes in 32 pages of 16, one page programmed at once.
// R5 - The master keeps the clock at or below 400 kHz, or 100 kHz at low supply; the bench master runs at 500 kHz (q of 5) outside the polling test.
// R6 - The device is only a slave and answers only when addressed.
// R7 - The master starts every transfer and supplies every clock pulse.
// R8 - Standby follows a stop condition and the end of a programming cycle.
// R9 - Data falling while clock is high is a start, detected at any time.
// R10 - Data rising while clock is high is a stop, ending the communication.
// R11 - A stop after write data starts programming; a stop after reading does not, but here one does if write data came before a repeated start.
// R12 - After eight bits the sender releases data and the receiver pulls it low.
// R13 - Each byte received while addressed is acknowledged in the ninth clock.
// R14 - Data changes only while clock is low, apart from start and stop.
// R15 - A byte is nine clock pulses: eight data bits, MSB first, then acknowledge.
// R16 - A command byte follows each start, then a control byte it selects.
// R17 - Command bit zero is the direction: zero writes, one reads.
// R18 - Write command bit one is the upper address bit; other low bits ignored.
// R19 - The byte after a write command loads the low eight address bits.
// R20 - After a read command, data bytes are sent while the master acknowledges.
// R21 - The master ends a read by withholding acknowledge, then sending stop.
// R22 - The address advances after each acknowledged write byte and each read byte.
// R23 - Write bursts advance only the four low address bits, staying in one page.
// R24 - No command byte is acknowledged while a programming cycle runs.
// R25 - Each programming cycle completes within 8 ms of its stop condition.
// R26 - Both bus lines are synchronised and deglitched before any edge detection.
package eep_pkg;

  // ---------------------------------------------------------------
  // Memory organisation
  // ---------------------------------------------------------------
  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W = 9;
  localparam int PAGE_W = 5;
  localparam int OFFS_W = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // Command byte fields
  // ---------------------------------------------------------------
  localparam int CMD_DIR_BIT = 0;
  localparam int CMD_UPPER_ADDR_BIT = 1;
  localparam int CMD_SEL_HI = 7;
  localparam int CMD_SEL_LO = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_KHZ = 10000;
  localparam int PROG_TIME_MS = 8;
  localparam int PROG_CYCLES = PROG_TIME_MS * REF_CLK_KHZ;
  localparam int PROG_CNT_W = 17;

  // ---------------------------------------------------------------
  // Slave sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD,
    ST_CMD_ACK,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK
  } eep_state_t;

endpackage : eep_pkg

//--- logic/eep_line_filter.sv
// Three-stage synchroniser and agreement filter for the bus lines and the write-protect pin.
`timescale 1ns/100ps
module eep_line_filter
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] line_in,
  output logic [2:0] line_out
);

  // ---------------------------------------------------------------
  // Per-line synchroniser
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_line
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic filt_reg;

      // The level only moves once the second and third stages agree; all reset high.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          s3_reg <= 1'b1;
          filt_reg <= 1'b1;
        end
        else
        begin
          s1_reg <= line_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
          begin
            filt_reg <= s3_reg; // R26
          end
        end
      end

      assign line_out[i] = filt_reg;
    end
  endgenerate

endmodule : eep_line_filter

//--- testbench/eep_slave_properties.sv
// Concurrent checks on the ports of the EEPROM slave front end.
`timescale 1ns/100ps
module eep_slave_props
#(
  parameter int PROG_CYCLES = 50
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic WP,
  input wire logic BUSY,
  input wire logic ADDRESSED
);
  // ----
  // Helper logic
  // ----
  // Counts the cycles of the running programming cycle.
  logic [31:0] busy_cnt_reg;
  wire [31:0] busy_cnt_next = BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= busy_cnt_next;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // Bus conditions seen on the raw pins.
  sequence s_start;
    SCL && $fell(SDA_IN);
  endsequence
  sequence s_stop;
    SCL && $rose(SDA_IN);
  endsequence

  // ----
  // Properties
  // ----
  property p_od_low;
    SDA_OUT == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("data pin driven high");
  property p_oe_scl_low;
    $changed(SDA_OE) |-> (!SCL) [*4];
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved near clock");
  property p_ack_addr;
    $rose(SDA_OE) |-> ADDRESSED;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("pulled while not addressed");
  property p_busy_quiet;
    BUSY |-> !SDA_OE && !ADDRESSED;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("answered while busy");
  property p_prog_len;
    $fell(BUSY) |-> busy_cnt_reg == PROG_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming length wrong");
  property p_wp_block;
    WP && !BUSY |=> !BUSY;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("programmed while protected");
  property p_stop_idle;
    s_stop |-> ##8 (!ADDRESSED && !SDA_OE);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("not idle after stop");
  property p_start_idle;
    s_start |-> ##8 !ADDRESSED;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start not restarting");
endmodule : eep_slave_props

bind eep_slave eep_slave_props #(.PROG_CYCLES(PROG_CYCLES)) u_props
(
  .REF_CLK(REF_CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .WP(WP), .BUSY(BUSY), .ADDRESSED(ADDRESSED)
);

//--- testbench/eep_master_model.sv
// Behavioural two-wire bus master that clocks the EEPROM slave.
`timescale 1ns/100ps
module eep_master_model
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  // Quarter bus clock period in reference cycles; raise it for a slow master.
  int q = 5;
  // The bus rests idle high.
  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // Waits reference clock falls so changes land off the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Issues a start from idle or as a repeated start.
  task automatic start_cond();
    pull_low = 1'b0;
    tick(q);
    scl = 1'b1;
    tick(2 * q);
    pull_low = 1'b1;
    tick(2 * q);
    scl = 1'b0;
    tick(q);
  endtask : start_cond
  // Issues a stop and leaves the bus idle.
  task automatic stop_cond();
    pull_low = 1'b1;
    tick(q);
    scl = 1'b1;
    tick(2 * q);
    pull_low = 1'b0;
    tick(2 * q);
  endtask : stop_cond
  // Shifts nine bits MSB first; a one releases the line for the slave.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      pull_low = !tx[i];
      tick(q);
      scl = 1'b1;
      tick(q);
      rx[i] = sda;
      tick(q);
      scl = 1'b0;
      tick(q);
    end
  endtask : xfer
endmodule : eep_master_model

//--- testbench/tb_eep_slave.sv
// Self-checking bench for the EEPROM slave front end.
`timescale 1ns/100ps
module tb_eep_slave;
  localparam int PROG = 600;
  localparam logic [3:0] SEL = 4'h5; // Arbitrary device select code.
  typedef struct {logic [8:0] a; logic [7:0] d;} eep_row_t;
  // Each row writes one byte and reads it back.
  eep_row_t rows [4] = '{'{9'h000, 8'hA5}, '{9'h1FF, 8'h5A},
    '{9'h100, 8'h00}, '{9'h0AB, 8'hFF}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic scl, m_low, sda_oe, sda_out, busy, addressed;
  logic [7:0] exp_mem [512];
  logic [8:0] rx, ptr;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // The wire is pulled up unless a party pulls it low.
  wire sda = (sda_oe ? sda_out : 1'b1) && !m_low;

  eep_slave #(.PROG_CYCLES(PROG), .DEV_SEL(SEL)) dut
  (
    .REF_CLK(ref_clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .WP(wp), .BUSY(busy), .ADDRESSED(addressed)
  );
  eep_master_model mst
  (
    .clk(ref_clk), .sda(sda), .scl(scl), .pull_low(m_low)
  );

  // ----
  // Clock, timeout and helpers
  // ----
  // Runs the reference clock.
  initial
  begin
    forever #50 ref_clk = !ref_clk;
  end
  // Cuts a hung run short.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      test_done();
    end
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Sends a byte and checks the acknowledge, low for taken.
  task automatic send(input logic [7:0] b, input logic ack);
    mst.xfer({b, 1'b1}, rx);
    chk("ack", {8'h0, ack}, {8'h0, rx[0]});
  endtask : send
  // Starts and loads the address counter.
  task automatic set_addr(input logic [8:0] a);
    mst.start_cond();
    send({SEL, 2'b11, a[8], 1'b0}, 1'b0);
    send(a[7:0], 1'b0);
  endtask : set_addr
  // Reads n bytes from the counter, acknowledging all but the last.
  task automatic rd_cur(input int n, inout logic [8:0] p);
    mst.start_cond();
    send({SEL, 3'h7, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      mst.xfer({8'hFF, i == n - 1}, rx);
      chk("read", {1'b0, exp_mem[p]}, {1'b0, rx[8:1]});
      p = p + 9'h1;
    end
    mst.stop_cond();
  endtask : rd_cur
  // Writes n counting bytes from an address and stops.
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0);
    set_addr(a);
    for (int i = 0; i < n; i++)
    begin
      send(d0 + 8'(i), 1'b0);
      if (!wp)
        exp_mem[a] = d0 + 8'(i);
      a = {a[8:4], a[3:0] + 4'h1};
    end
    mst.stop_cond();
  endtask : wr
  // Checks for a programming cycle and waits, bounded, for standby.
  task automatic prog_wait(input logic on);
    logic seen;
    seen = 1'b0;
    repeat (20)
    begin
      @(negedge ref_clk);
      seen = seen | busy;
    end
    chk("busy", {8'h0, on}, {8'h0, seen});
    for (int i = 0; i < PROG + 40 && busy !== 1'b0; i++)
      @(negedge ref_clk);
    chk("standby", 9'h0, {8'h0, busy});
  endtask : prog_wait
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ----
  // Tests
  // ----
  // Resets, runs the table, then the awkward cases.
  initial
  begin
    for (int i = 0; i < 512; i++)
      exp_mem[i] = 8'hFF;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("idle", 9'h0, {6'h0, busy, sda_oe, addressed});
    foreach (rows[i])
    begin
      wr(rows[i].a, 1, rows[i].d);
      prog_wait(1'b1);
      set_addr(rows[i].a);
      ptr = rows[i].a;
      rd_cur(1, ptr);
    end
    $display("test table done");
    set_addr(9'h1FF);
    ptr = 9'h1FF;
    rd_cur(2, ptr);
    rd_cur(1, ptr);
    $display("test rollover done");
    wr(9'h0FE, 3, 8'h11);
    prog_wait(1'b1);
    set_addr(9'h0FE);
    ptr = 9'h0FE;
    rd_cur(2, ptr);
    set_addr(9'h0F0);
    ptr = 9'h0F0;
    rd_cur(1, ptr);
    $display("test page done");
    mst.q = 8;
    wr(9'h055, 1, 8'h3C);
    mst.start_cond();
    send({SEL, 4'h0}, 1'b1);
    mst.stop_cond();
    prog_wait(1'b1);
    set_addr(9'h055);
    ptr = 9'h055;
    rd_cur(1, ptr);
    mst.q = 5;
    $display("test polling done");
    wp = 1'b1;
    wr(9'h055, 1, 8'hC3);
    prog_wait(1'b0);
    wp = 1'b0;
    ptr = 9'h056;
    rd_cur(1, ptr);
    prog_wait(1'b0);
    set_addr(9'h055);
    ptr = 9'h055;
    rd_cur(1, ptr);
    $display("test protect done");
    mst.start_cond();
    send({~SEL, 4'h0}, 1'b1);
    chk("addressed", 9'h0, {8'h0, addressed});
    mst.stop_cond();
    set_addr(9'h010);
    mst.stop_cond();
    prog_wait(1'b0);
    $display("test refusal done");
    mst.start_cond();
    send({SEL, 3'h0, 1'b0}, 1'b0);
    chk("addressed", 9'h1, {8'h0, addressed});
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk("reset", 9'h0, {6'h0, busy, sda_oe, addressed});
    mst.stop_cond();
    rst_n = 1'b1;
    for (int i = 0; i < 512; i++)
      exp_mem[i] = 8'hFF;
    set_addr(9'h055);
    ptr = 9'h055;
    rd_cur(1, ptr);
    $display("test reset done");
    test_done();
  end
endmodule : tb_eep_slave
